// ===== verilog/term_port_cfg.svh
/*
 * Address map, flag masks, reset values and sizes of the emulated serial
 * terminal port.
 * Assumes a byte-wide processor bus with 16-bit byte addresses.
 */
`ifndef TERM_PORT_CFG_SVH
`define TERM_PORT_CFG_SVH

// ============================================================
// Address map
`define ADDR_W            16
`define ADDR_RATE         16'h0200
`define ADDR_CTRL_ONE     16'h0201
`define ADDR_CTRL_TWO     16'h0202
`define ADDR_STATUS       16'h0203
`define ADDR_DATA         16'h0204

// ============================================================
// Status flags
`define TX_EMPTY_MASK     8'h80
`define RX_FULL_MASK      8'h20

// ============================================================
// Reset values and sizes
`define BYTE_ZERO         8'h00
`define DATA_W            8
`define TX_FIFO_DEPTH     16

`endif

// ===== verilog/term_port_pkg.sv
/*
 * Types shared by the emulated serial terminal port.
 * Assumes term_port_cfg.svh is on the include path.
 */
`include "term_port_cfg.svh"

package term_port_pkg;

    // ============================================================
    // One processor bus cycle
    typedef struct packed {
        logic                 rd;
        logic                 wr;
        logic [`ADDR_W-1:0]   addr;
        logic [`DATA_W-1:0]   wdata;
    } bus_req_t;

    typedef logic [`DATA_W-1:0] byte_t;

endpackage : term_port_pkg

// ===== verilog/term_port.sv
/*
 * Emulated serial terminal port: five byte registers on the processor bus,
 * a typed-character input and a displayed-character output, with a
 * transmit FIFO between the data register and the terminal.
 * Assumes one clock, synchronous inputs, and strobes of one cycle each.
 */
// Function
// - The register group is decoded at base 0x200 and covers five byte addresses.
// - Rate at 0x200, control one at 0x201, control two at 0x202, status at 0x203, data at 0x204.
// - Status bit with mask 0x80 reads set when a new byte may be written.
// - Status bit with mask 0x20 reads set when a received byte is waiting.
// - Rate, control and status accesses are accepted but change no behaviour.
// - Reception and transmission work with no configuration writes.
// - The data register returns the received byte on reads and takes a byte to send on writes.
// - Reading the data register clears the receive-full flag.
// - A typed character is loaded into the data register and sets the receive-full flag.
// - A data write queues the byte and transmit-empty stays set with no delay unless the transmit FIFO is full.
`timescale 1ns/1ps
`include "term_port_cfg.svh"

// ============================================================
// Transmit FIFO
module term_tx_fifo #(
    parameter int WIDTH = `DATA_W,
    parameter int DEPTH = `TX_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             nrst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = PW + 1;
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0]    wr_ptr_ff;
    logic [PW-1:0]    rd_ptr_ff;
    logic [CW-1:0]    count_ff;
    logic             push;
    logic             pop;

    assign in_ready  = (count_ff != FULL_CNT);
    assign out_valid = (count_ff != '0);
    assign out_data  = mem_ff[rd_ptr_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // ============================================================
    // Storage; no reset needed since reads are gated by count
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    // ============================================================
    // Pointers
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == LAST_PTR) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == LAST_PTR) ? '0 : rd_ptr_ff + 1'b1;
            end
        end
    end

    // ============================================================
    // Occupancy
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            count_ff <= '0;
        end else if (push && !pop) begin
            count_ff <= count_ff + 1'b1;
        end else if (pop && !push) begin
            count_ff <= count_ff - 1'b1;
        end
    end

endmodule : term_tx_fifo

// ============================================================
// Register block and terminal side
module term_port (
    // Clock and reset
    input  wire logic                    mclk,
    input  wire logic                    nrst,
    // Processor bus
    input  wire term_port_pkg::bus_req_t bus_req,
    output term_port_pkg::byte_t         bus_rdata_ff,
    output logic                         bus_ack_ff,
    // Typed characters from the terminal
    input  wire logic                    term_rx_valid,
    input  wire term_port_pkg::byte_t    term_rx_data,
    output logic                         term_rx_ready_ff,
    // Characters to the terminal display
    output logic                         term_tx_valid_ff,
    output term_port_pkg::byte_t         term_tx_data_ff,
    input  wire logic                    term_tx_ready
);
    import term_port_pkg::*;

    byte_t rate_setting_ff;
    byte_t serial_control_one_ff;
    byte_t serial_control_two_ff;
    byte_t rx_data_ff;
    logic  receive_full_flag_ff;
    logic  sel_rate;
    logic  sel_ctrl_one;
    logic  sel_ctrl_two;
    logic  sel_status;
    logic  sel_data;
    logic  sel_any;
    logic  rx_fire;
    logic  data_read;
    logic  nxt_receive_full;
    logic  transmit_empty_flag;
    logic  fifo_out_valid;
    logic  fifo_out_ready;
    byte_t fifo_out_data;
    byte_t nxt_rdata;

    // ============================================================
    // Address decode
    assign sel_rate     = (bus_req.addr == `ADDR_RATE);
    assign sel_ctrl_one = (bus_req.addr == `ADDR_CTRL_ONE);
    assign sel_ctrl_two = (bus_req.addr == `ADDR_CTRL_TWO);
    assign sel_status   = (bus_req.addr == `ADDR_STATUS);
    assign sel_data     = (bus_req.addr == `ADDR_DATA);
    assign sel_any      = sel_rate | sel_ctrl_one | sel_ctrl_two | sel_status | sel_data;

    // ============================================================
    // Dummy registers kept only so drivers that set them still work
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rate_setting_ff       <= `BYTE_ZERO;
            serial_control_one_ff <= `BYTE_ZERO;
            serial_control_two_ff <= `BYTE_ZERO;
        end else if (bus_req.wr) begin
            if (sel_rate) begin
                rate_setting_ff <= bus_req.wdata;
            end
            if (sel_ctrl_one) begin
                serial_control_one_ff <= bus_req.wdata;
            end
            if (sel_ctrl_two) begin
                serial_control_two_ff <= bus_req.wdata;
            end
        end
    end

    // ============================================================
    // Receive side
    assign rx_fire   = term_rx_valid && term_rx_ready_ff;
    assign data_read = bus_req.rd && sel_data;
    // Arrival wins over a clearing read in the same cycle
    assign nxt_receive_full = rx_fire | (receive_full_flag_ff & ~data_read);

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            receive_full_flag_ff <= 1'b0;
            term_rx_ready_ff     <= 1'b1;
        end else begin
            receive_full_flag_ff <= nxt_receive_full;
            term_rx_ready_ff     <= ~nxt_receive_full;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rx_data_ff <= `BYTE_ZERO;
        end else if (rx_fire) begin
            rx_data_ff <= term_rx_data;
        end
    end

    // ============================================================
    // Transmit side; a write while the FIFO is full is dropped
    term_tx_fifo #(
        .WIDTH (`DATA_W),
        .DEPTH (`TX_FIFO_DEPTH)
    ) u_tx_fifo (
        .mclk      (mclk),
        .nrst      (nrst),
        .in_valid  (bus_req.wr && sel_data),
        .in_ready  (transmit_empty_flag),
        .in_data   (bus_req.wdata),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // Output stage keeps the terminal outputs registered
    assign fifo_out_ready = ~term_tx_valid_ff | term_tx_ready;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            term_tx_valid_ff <= 1'b0;
            term_tx_data_ff  <= `BYTE_ZERO;
        end else if (fifo_out_ready) begin
            term_tx_valid_ff <= fifo_out_valid;
            if (fifo_out_valid) begin
                term_tx_data_ff <= fifo_out_data;
            end
        end
    end

    // ============================================================
    // Read path; reserved and unmapped bits read as zero
    always_comb begin
        nxt_rdata = `BYTE_ZERO;
        if (bus_req.rd) begin
            unique case (1'b1)
                sel_rate:     nxt_rdata = rate_setting_ff;
                sel_ctrl_one: nxt_rdata = serial_control_one_ff;
                sel_ctrl_two: nxt_rdata = serial_control_two_ff;
                sel_status:   nxt_rdata = (transmit_empty_flag  ? `TX_EMPTY_MASK : `BYTE_ZERO)
                                        | (receive_full_flag_ff ? `RX_FULL_MASK  : `BYTE_ZERO);
                sel_data:     nxt_rdata = rx_data_ff;
                default:      nxt_rdata = `BYTE_ZERO;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            bus_rdata_ff <= `BYTE_ZERO;
            bus_ack_ff   <= 1'b0;
        end else begin
            bus_rdata_ff <= nxt_rdata;
            bus_ack_ff   <= (bus_req.rd | bus_req.wr) & sel_any;
        end
    end

    // ============================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    property p_decode;
        (bus_req.rd | bus_req.wr) && !sel_any |=> !bus_ack_ff && bus_rdata_ff == `BYTE_ZERO;
    endproperty
    a_decode: assert property (p_decode) else $error("Unmapped access answered");

    property p_map;
        bus_req.rd && bus_req.addr == `ADDR_RATE |=> bus_ack_ff && bus_rdata_ff == $past(rate_setting_ff);
    endproperty
    a_map: assert property (p_map) else $error("Rate register misplaced");

    property p_tx_flag;
        bus_req.rd && sel_status |=> bus_rdata_ff[7] == $past(transmit_empty_flag);
    endproperty
    a_tx_flag: assert property (p_tx_flag) else $error("Transmit-empty bit wrong");

    property p_rx_flag;
        bus_req.rd && sel_status |=> bus_rdata_ff[5] == $past(receive_full_flag_ff);
    endproperty
    a_rx_flag: assert property (p_rx_flag) else $error("Receive-full bit wrong");

    property p_dummy;
        bus_req.wr && !sel_data && !rx_fire && !data_read
            |=> receive_full_flag_ff == $past(receive_full_flag_ff) && rx_data_ff == $past(rx_data_ff)
                && u_tx_fifo.count_ff <= $past(u_tx_fifo.count_ff);
    endproperty
    a_dummy: assert property (p_dummy) else $error("Dummy write changed state");

    property p_boot;
        disable iff (1'b0)
        !nrst |=> term_rx_ready_ff && !receive_full_flag_ff && !term_tx_valid_ff;
    endproperty
    a_boot: assert property (p_boot) else $error("Not ready after reset");

    property p_data_rd;
        data_read |=> bus_rdata_ff == $past(rx_data_ff);
    endproperty
    a_data_rd: assert property (p_data_rd) else $error("Data read wrong byte");

    property p_clear;
        data_read && !rx_fire |=> !receive_full_flag_ff ##1 term_rx_ready_ff || receive_full_flag_ff;
    endproperty
    a_clear: assert property (p_clear) else $error("Read did not clear flag");

    property p_load;
        rx_fire |=> receive_full_flag_ff && rx_data_ff == $past(term_rx_data) && !term_rx_ready_ff;
    endproperty
    a_load: assert property (p_load) else $error("Typed char not loaded");

    property p_send;
        bus_req.wr && sel_data && !fifo_out_valid && !term_tx_valid_ff
            |=> transmit_empty_flag ##1 term_tx_valid_ff && term_tx_data_ff == $past(bus_req.wdata, 2);
    endproperty
    a_send: assert property (p_send) else $error("Written byte not sent");

endmodule : term_port

// ===== verification/term_model.sv
/*
 * Terminal model for the emulated serial terminal port: a keyboard that
 * types characters and a display that collects them, with a stall input.
 * Assumes term_port_pkg is compiled first and that inputs change at negedge.
 */
`timescale 1ns/1ps

// ============================================================
// Keyboard and display
module term_model (
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 nrst,
    // Keyboard side
    output logic                      term_rx_valid,
    output term_port_pkg::byte_t      term_rx_data,
    input  wire logic                 term_rx_ready_ff,
    // Display side
    input  wire logic                 term_tx_valid_ff,
    input  wire term_port_pkg::byte_t term_tx_data_ff,
    output logic                      term_tx_ready,
    // Test control
    input  wire logic                 stall
);
    import term_port_pkg::*;

    byte_t shown_q[$];

    initial begin
        term_rx_valid = 1'b0;
        term_rx_data  = 8'h5a;
    end

    // Stalling the display lets the transmit buffer fill
    assign term_tx_ready = ~stall;

    always @(posedge mclk) begin
        if (nrst && term_tx_valid_ff && term_tx_ready) begin
            shown_q.push_back(term_tx_data_ff);
        end
    end

    // Key held until taken; data scrambled once released, not left stale
    task automatic type_key(input byte_t code);
        @(negedge mclk);
        term_rx_valid = 1'b1;
        term_rx_data  = code;
        @(posedge mclk);
        while (term_rx_ready_ff !== 1'b1) @(posedge mclk);
        @(negedge mclk);
        term_rx_valid = 1'b0;
        term_rx_data  = ~code;
    endtask : type_key

endmodule : term_model

// ===== verification/term_port_tb.sv
/*
 * Self-checking testbench for the emulated serial terminal port.
 * Assumes the design package, header and term_model are compiled first.
 */
`timescale 1ns/1ps
`include "term_port_cfg.svh"

module term_port_tb;
    import term_port_pkg::*;

    // ============================================================
    // Signals
    logic       mclk, nrst, stall;
    bus_req_t   bus_req;
    byte_t      bus_rdata_ff, term_rx_data, term_tx_data_ff, rd_val;
    logic       bus_ack_ff, term_rx_valid, term_rx_ready_ff, term_tx_valid_ff, term_tx_ready, ack_val;
    int         error_cnt, total_checks, i;
    logic [15:0] bad_addr[2] = '{16'h01ff, 16'h0205};

    always #25 mclk = ~mclk;

    term_port uut (.mclk(mclk), .nrst(nrst), .bus_req(bus_req), .bus_rdata_ff(bus_rdata_ff),
                   .bus_ack_ff(bus_ack_ff), .term_rx_valid(term_rx_valid), .term_rx_data(term_rx_data),
                   .term_rx_ready_ff(term_rx_ready_ff), .term_tx_valid_ff(term_tx_valid_ff),
                   .term_tx_data_ff(term_tx_data_ff), .term_tx_ready(term_tx_ready));

    term_model tm (.mclk(mclk), .nrst(nrst), .term_rx_valid(term_rx_valid), .term_rx_data(term_rx_data),
                   .term_rx_ready_ff(term_rx_ready_ff), .term_tx_valid_ff(term_tx_valid_ff),
                   .term_tx_data_ff(term_tx_data_ff), .term_tx_ready(term_tx_ready), .stall(stall));

    // ============================================================
    // Compare, bus and closing tasks
    task automatic chk_byte(input byte_t got, input byte_t exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic chk_flag(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_flag

    // One strobe cycle; answer is registered, so taken one edge later
    task automatic bus_op(input logic rd, input logic wr, input logic [15:0] addr, input byte_t wdata);
        @(negedge mclk);
        bus_req = '{rd: rd, wr: wr, addr: addr, wdata: wdata};
        @(negedge mclk);
        ack_val = bus_ack_ff;
        rd_val  = bus_rdata_ff;
        bus_req = '0;
    endtask : bus_op

    task automatic reg_read(input logic [15:0] addr, input byte_t exp);
        bus_op(1'b1, 1'b0, addr, 8'h00);
        chk_flag(ack_val, 1'b1);
        chk_byte(rd_val, exp);
    endtask : reg_read

    task automatic reg_write(input logic [15:0] addr, input byte_t d);
        bus_op(1'b0, 1'b1, addr, d);
        chk_flag(ack_val, 1'b1);
    endtask : reg_write

    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    // ============================================================
    // Watchdog
    initial begin
        repeat (5000) @(posedge mclk);
        error_cnt++;
        end_of_test();
    end

    // ============================================================
    // Tests
    initial begin
        mclk = 1'b0;
        nrst = 1'b0;
        stall = 1'b0;
        bus_req = '0;
        error_cnt = 0;
        total_checks = 0;
        repeat (10) @(negedge mclk);
        nrst = 1'b1;
        reg_read(`ADDR_STATUS, `TX_EMPTY_MASK);
        for (i = 0; i < 3; i++) reg_read(`ADDR_RATE + 16'(i), `BYTE_ZERO);
        for (i = 0; i < 2; i++) begin
            bus_op(1'b1, 1'b0, bad_addr[i], 8'h00);
            chk_flag(ack_val, 1'b0);
            chk_byte(rd_val, `BYTE_ZERO);
        end
        for (i = 0; i < 3; i++) reg_write(`ADDR_RATE + 16'(i), 8'h30 + 8'(i));
        for (i = 0; i < 3; i++) reg_read(`ADDR_RATE + 16'(i), 8'h30 + 8'(i));
        reg_write(`ADDR_STATUS, 8'hff);
        reg_read(`ADDR_STATUS, `TX_EMPTY_MASK);
        // Receive path: flag set by a key, cleared by the data read
        tm.type_key(8'h41);
        reg_read(`ADDR_STATUS, `TX_EMPTY_MASK | `RX_FULL_MASK);
        reg_read(`ADDR_DATA, 8'h41);
        reg_read(`ADDR_STATUS, `TX_EMPTY_MASK);
        tm.type_key(8'h7e);
        reg_read(`ADDR_DATA, 8'h7e);
        // Transmit path: empty flag back at once
        reg_write(`ADDR_DATA, 8'h48);
        reg_read(`ADDR_STATUS, `TX_EMPTY_MASK);
        for (i = 0; i < 20 && tm.shown_q.size() == 0; i++) @(negedge mclk);
        chk_byte(8'(tm.shown_q.size()), 8'h01);
        chk_byte(tm.shown_q[0], 8'h48);
        // Stalled display: 17 bytes fit, then flag drops and writes are lost
        stall = 1'b1;
        for (i = 0; i < 17; i++) reg_write(`ADDR_DATA, 8'h60 + 8'(i));
        reg_read(`ADDR_STATUS, `BYTE_ZERO);
        reg_write(`ADDR_DATA, 8'hee);
        @(negedge mclk);
        stall = 1'b0;
        repeat (25) @(negedge mclk);
        chk_byte(8'(tm.shown_q.size()), 8'h12);
        for (i = 0; i < 17; i++) chk_byte(tm.shown_q[i + 1], 8'h60 + 8'(i));
        reg_read(`ADDR_STATUS, `TX_EMPTY_MASK);
        end_of_test();
    end

endmodule : term_port_tb
